// ===== bench/smcm_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Checks the pin behaviour of the static memory mode logic.
module smcm_ctrl_sva (
  input wire logic clock,
  input wire logic reset,
  input wire logic reqValid,
  input wire smcm_pkg::smcm_req_t req,
  input wire logic reqReady,
  input wire logic rdValid,
  input wire logic busBusy,
  input wire smcm_pkg::smcm_pins_t pins
);
  smcm_pkg::smcm_req_t reqQ, fltQ, src;
  logic busQ;
  logic [4:0] cntQ;
  logic wide;
  // Keeps the taken request, the read owning the float and its length.
  always_ff @(posedge clock) begin
    if (reset) begin
      reqQ <= '0;
      fltQ <= '0;
      busQ <= 1'b0;
      cntQ <= 5'h00;
    end else begin
      if (reqValid && reqReady) reqQ <= req;
      fltQ <= src;
      busQ <= busBusy;
      cntQ <= busBusy ? cntQ + 5'h01 : 5'h00;
    end
  end
  // The float owner is frozen from the first busy cycle on.
  assign src = busQ ? fltQ : reqQ;
  assign wide = reqQ.mode.busWidthSel inside {smcm_pkg::WIDTH_16,
    smcm_pkg::WIDTH_32};
  default clocking @(posedge clock); endclocking
  default disable iff reset;
  bat_ignored_a: assert property (!wide |-> &pins.byteWriteStrobeN)
    else $error("byte strobes used on a narrow bus");
  byte_write_a: assert property (wide && reqQ.mode.byteAccessType |->
    pins.writeStrobeN) else $error("common strobe in byte write mode");
  byte_select_a: assert property (!reqQ.mode.byteAccessType |->
    &pins.byteWriteStrobeN) else $error("byte strobe in byte select mode");
  width_lanes_a: assert property (reqQ.mode.busWidthSel ==
    smcm_pkg::WIDTH_16 |-> &pins.byteSelectN[3:2]
    && &pins.byteWriteStrobeN[3:2]) else $error("upper lanes on 16 bits");
  float_len_a: assert property (!busBusy && cntQ != 5'h00 |-> cntQ ==
    {1'b0, src.mode.floatCycleCount} + 5'h01)
    else $error("float period has the wrong length");
  float_block_a: assert property (busBusy |-> pins.writeStrobeN
    && &pins.byteWriteStrobeN
    && (pins.readStrobeN || !pins.chipSelN[src.chipSel]))
    else $error("bus used during the float period");
  no_setup_a: assert property (busBusy && !src.mode.floatOptimizeEn |->
    (pins.chipSelN | (8'h01 << src.chipSel)) == 8'hff)
    else $error("setup started during float");
  read_pulse_a: assert property (rdValid |-> pins.readStrobeN
    && !$past(pins.readStrobeN)) else $error("read data not at strobe rise");
  turnaround_oe_a: assert property (busBusy |-> !pins.dataOe)
    else $error("data driven during float or turnaround");
  cover property (reqValid && reqReady && req.write);
  cover property (!busBusy && cntQ == 5'h10);
  cover property (rdValid && reqQ.mode.pageReadEn);
endmodule : smcm_ctrl_sva
bind smcm_static_mem_ctrl smcm_ctrl_sva u_sva (.clock(clock), .reset(reset),
  .reqValid(reqValid), .req(req), .reqReady(reqReady), .rdValid(rdValid),
  .busBusy(busBusy), .pins(pins));
`default_nettype wire

// ===== bench/smcm_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// External memory: answers a read pulse with a word tagged by the selects.
module smcm_mem_model (
  input wire logic clock,
  input wire smcm_pkg::smcm_pins_t pins,
  output logic [31:0] dataIn
);
  logic [31:0] lastQ = 32'h00000000;
  logic drive;
  // A released bus shows the inverse of the last word, never a stale copy.
  assign drive = !pins.readStrobeN && !(&pins.chipSelN);
  assign dataIn = drive ? {24'ha5c3e1, pins.chipSelN} : ~lastQ;
  // Remembers the word last driven.
  always @(posedge clock) begin
    if (drive) lastQ <= dataIn;
  end
endmodule : smcm_mem_model
`default_nettype wire

// ===== bench/static_mem_cs_mode_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module static_mem_cs_mode_control_test;
  logic clock, reset, reqValid, reqReady, rdValid, busBusy;
  smcm_pkg::smcm_req_t req;
  smcm_pkg::smcm_pins_t pins;
  logic [31:0] rdData, dataIn, busyCnt;
  logic sWe, sOe, sSelBusy, sWeBusy;
  logic [31:0] sDat;
  logic [3:0] sBw, sBs;
  int errors = 0;
  int nChecks = 0;
  int rdAt;
  smcm_static_mem_ctrl u_dut (.clock(clock), .reset(reset),
    .reqValid(reqValid), .req(req), .reqReady(reqReady), .rdValid(rdValid),
    .rdData(rdData), .busBusy(busBusy), .pins(pins), .dataIn(dataIn));
  smcm_mem_model u_mem (.clock(clock), .pins(pins), .dataIn(dataIn));
  // Free running clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Waits for idle, hands over one access and records what the pins did.
  task automatic access(input logic w, input logic [2:0] cs,
    input smcm_pkg::smcm_mode_t m);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1 n++;
    end
    req.write = w;
    req.chipSel = cs;
    req.mode = m;
    reqValid = 1'b1;
    @(posedge clock);
    #1 reqValid = 1'b0;
    {sWe, sOe, sSelBusy, sWeBusy, sBw, sBs, busyCnt, sDat, rdAt} = '0;
    while (reqReady !== 1'b1 && n < 600) begin
      sWe |= !pins.writeStrobeN;
      sBw |= ~pins.byteWriteStrobeN;
      sBs |= ~pins.byteSelectN;
      sOe |= pins.dataOe;
      if (pins.dataOe === 1'b1) sDat = pins.dataOut;
      sSelBusy |= busBusy && !pins.chipSelN[cs];
      sWeBusy |= busBusy && !pins.writeStrobeN;
      if (rdValid === 1'b1) rdAt = n;
      if (busBusy === 1'b1) busyCnt++;
      @(posedge clock);
      #1 n++;
    end
    if (n >= 600) begin
      errors++;
      $display("ERROR at %0t: access timed out", $time);
      report_and_stop();
    end
  endtask : access
  // Counts the remaining float cycles after an access.
  task automatic settle;
    for (int n = 0; n < 40 && busBusy === 1'b1; n++) begin
      busyCnt++;
      @(posedge clock);
      #1;
    end
    if (busBusy === 1'b1) begin
      errors++;
      $display("ERROR at %0t: busy %h expected %h", $time, busBusy, 1'b0);
      report_and_stop();
    end
  endtask : settle
  task automatic test_write_lanes;
    smcm_pkg::smcm_mode_t m;
    logic [3:0] ln;
    m = '0;
    for (int b = 0; b < 2; b++) begin
      for (int w = 0; w < 4; w++) begin
        m.byteAccessType = b[0];
        m.busWidthSel = w[1:0];
        ln = w == 1 ? smcm_pkg::LANES_16 : smcm_pkg::LANES_32;
        access(1'b1, 3'h1, m);
        if (w == 1 || w == 2) begin
          check({sWe, sBw, sBs}, b ? {1'b0, ln, 4'h0} : {1'b1, 4'h0, ln});
        end else begin
          check({sWe, sBw, sBs}, 9'h100);
        end
        check(sDat, req.wdata);
      end
    end
    $display("test_write_lanes done");
  endtask : test_write_lanes
  task automatic test_read_float;
    smcm_pkg::smcm_mode_t m;
    logic [31:0] inAcc;
    m = '0;
    m.busWidthSel = smcm_pkg::WIDTH_32;
    for (int i = 0; i < 3; i++) begin
      m.floatCycleCount = i == 0 ? 4'h0 : i == 1 ? 4'h7 : 4'hf;
      m.readModeStrobe = i[0];
      access(1'b0, 3'h2, m);
      inAcc = busyCnt;
      settle();
      check(rdData, 32'ha5c3e1fb);
      check(busyCnt, {28'h0, m.floatCycleCount} + 32'h1);
      check(inAcc, m.readModeStrobe ? 32'h2 : 32'h0);
      check({31'h0, sOe}, 32'h0);
    end
    $display("test_read_float done");
  endtask : test_read_float
  task automatic test_float_block;
    smcm_pkg::smcm_mode_t m;
    m = '0;
    m.busWidthSel = smcm_pkg::WIDTH_32;
    m.floatCycleCount = 4'h9;
    m.readModeStrobe = 1'b1;
    for (int o = 0; o < 2; o++) begin
      m.floatOptimizeEn = o[0];
      access(1'b0, 3'h0, m);
      access(1'b1, 3'h3, m);
      check({sSelBusy, sWeBusy}, {o[0], 1'b0});
    end
    $display("test_float_block done");
  endtask : test_float_block
  task automatic test_page;
    smcm_pkg::smcm_mode_t m;
    int t1;
    int t2;
    logic [23:0] pg;
    m = '0;
    m.busWidthSel = smcm_pkg::WIDTH_32;
    m.pageReadEn = 1'b1;
    req.csReadPulseLen = 7'h06;
    req.readStrobePulseLen = 7'h03;
    for (int p = 0; p < 4; p++) begin
      m.pageSizeSel = p[1:0];
      pg = 24'h000004 << p;
      req.addr = 24'h000000;
      access(1'b1, 3'h4, m);
      access(1'b0, 3'h4, m);
      t1 = rdAt;
      req.addr = pg - 24'h000001;
      access(1'b0, 3'h4, m);
      t2 = rdAt;
      check(rdData, 32'ha5c3e1ef);
      check({31'h0, t2 < t1}, 32'h1);
      req.addr = pg;
      access(1'b0, 3'h4, m);
      check({31'h0, rdAt == t1}, 32'h1);
    end
    $display("test_page done");
  endtask : test_page
  // Reset, then the scenarios in turn.
  initial begin
    reset = 1'b1;
    reqValid = 1'b0;
    req = '0;
    req.byteEn = 4'hf;
    req.wdata = 32'h3c5a96e1;
    req.setupLen = 6'h01;
    req.csReadPulseLen = 7'h04;
    req.readStrobePulseLen = 7'h04;
    req.writePulseLen = 7'h02;
    req.holdLen = 6'h01;
    repeat (10) @(posedge clock);
    #1 reset = 1'b0;
    test_write_lanes();
    test_read_float();
    test_float_block();
    test_page();
    report_and_stop();
  end
endmodule : static_mem_cs_mode_control_test
`default_nettype wire

// ===== design/smcm_pkg.sv
// Functional notes
// RL1 - Byte access type ignored on 8-bit bus.
// RL2 - Type 1: per-byte write strobes, plain reads.
// RL3 - Type 0: common write strobe plus byte selects.
// RL4 - Width code 00=8, 01=16, 10=32 bits.
// RL5 - Float count per access, 0 to 15 cycles.
// RL6 - One extra turnaround cycle after float period.
// RL7 - Other chip selects blocked float plus one cycles.
// RL8 - Float optimization overlaps float with next setup.
// RL9 - Without optimization, full float wait before start.
// RL10 - Page enable selects burst page reads per select.
// RL11 - Page size code selects 4/8/16/32 byte pages.
// RL12 - Read mode picks strobe or select as controller.
// RL13 - First page access select pulse, later strobe pulse.
package smcm_pkg;

  // Number of chip selects and field widths.
  localparam int NUM_CS = 8;
  localparam int CS_W = 3;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int LANES = 4;

  // Bus width codes.
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // Lane masks for each bus width.
  localparam logic [3:0] LANES_8 = 4'h1;
  localparam logic [3:0] LANES_16 = 4'h3;
  localparam logic [3:0] LANES_32 = 4'hf;

  // Smallest page is four bytes; the size code shifts it up.
  localparam logic [ADDR_W-1:0] PAGE_BASE_BYTES = 24'h000004;

  // Turnaround added after the float period, in cycles.
  localparam logic [4:0] TURNAROUND_CYCLES = 5'h01;

  // Access phases.
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD} smcm_phase_t;

  // Mode settings that travel with each access.
  typedef struct packed {
    logic byteAccessType;
    logic [1:0] busWidthSel;
    logic [3:0] floatCycleCount;
    logic floatOptimizeEn;
    logic pageReadEn;
    logic [1:0] pageSizeSel;
    logic readModeStrobe;
  } smcm_mode_t;

  // One access request with its timing figures in cycles.
  typedef struct packed {
    logic write;
    logic [CS_W-1:0] chipSel;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] byteEn;
    logic [DATA_W-1:0] wdata;
    logic [5:0] setupLen;
    logic [6:0] csReadPulseLen;
    logic [6:0] readStrobePulseLen;
    logic [6:0] writePulseLen;
    logic [5:0] holdLen;
    smcm_mode_t mode;
  } smcm_req_t;

  // External memory pins, all strobes active low.
  typedef struct packed {
    logic [NUM_CS-1:0] chipSelN;
    logic readStrobeN;
    logic writeStrobeN;
    logic [LANES-1:0] byteWriteStrobeN;
    logic [LANES-1:0] byteSelectN;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
  } smcm_pins_t;

  // Pin values while no access runs.
  localparam smcm_pins_t PINS_IDLE = '{
    chipSelN: 8'hff, readStrobeN: 1'b1, writeStrobeN: 1'b1,
    byteWriteStrobeN: 4'hf, byteSelectN: 4'hf,
    dataOut: 32'h00000000, dataOe: 1'b0};

endpackage : smcm_pkg

// ===== design/smcm_static_mem_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module smcm_static_mem_ctrl (
  input wire logic clock,
  input wire logic reset,
  input wire logic reqValid,
  input wire smcm_pkg::smcm_req_t req,
  output logic reqReady,
  output logic rdValid,
  output logic [smcm_pkg::DATA_W-1:0] rdData,
  output logic busBusy,
  output smcm_pkg::smcm_pins_t pins,
  input wire logic [smcm_pkg::DATA_W-1:0] dataIn
);

  //////////////////////////////////////////////////////////////////////////
  // State of the block.

  typedef struct packed {
    smcm_pkg::smcm_phase_t phase;
    logic [7:0] cnt;
    smcm_pkg::smcm_req_t cur;
    smcm_pkg::smcm_pins_t pins;
    logic [4:0] floatCnt;
    logic [smcm_pkg::CS_W-1:0] floatCs;
    logic floatOpt;
    logic pageOpen;
    logic [smcm_pkg::CS_W-1:0] pageCs;
    logic [smcm_pkg::ADDR_W-1:0] pageAddr;
    logic [smcm_pkg::DATA_W-1:0] dinMeta;
    logic [smcm_pkg::DATA_W-1:0] dinSync;
    logic reqReady;
    logic rdValid;
    logic busy;
    logic [smcm_pkg::DATA_W-1:0] rdData;
  } smcm_state_t;

  smcm_state_t s_q;
  smcm_state_t s_d;

  //////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Lanes that exist on the selected bus width.
  function automatic logic [3:0] laneMask(input logic [1:0] width);
    logic [3:0] m;
    m = smcm_pkg::LANES_8;
    if (width == smcm_pkg::WIDTH_16) begin
      m = smcm_pkg::LANES_16; // RL4
    end else if (width == smcm_pkg::WIDTH_32) begin
      m = smcm_pkg::LANES_32; // RL4
    end
    return m;
  endfunction : laneMask

  // True when the bus is 16 or 32 bits wide.
  function automatic logic isWide(input logic [1:0] width);
    return (width == smcm_pkg::WIDTH_16) || (width == smcm_pkg::WIDTH_32);
  endfunction : isWide

  // True while the float period forbids this access the data bus.
  function automatic logic floatBlocks(input logic [4:0] fc,
                                       input logic [2:0] fcs,
                                       input smcm_pkg::smcm_req_t r);
    return (fc != 5'h00) && !((fcs == r.chipSel) && !r.write); // RL7
  endfunction : floatBlocks

  // Address bits that name the page, for the selected page size.
  function automatic logic [23:0] pageBase(input logic [23:0] a,
                                           input logic [1:0] ps);
    logic [23:0] size;
    size = smcm_pkg::PAGE_BASE_BYTES << ps; // RL11
    return a & ~(24'(size - 24'h000001));
  endfunction : pageBase

  // Pin levels for a given state.
  function automatic smcm_pkg::smcm_pins_t pinsFor(input smcm_state_t st);
    smcm_pkg::smcm_pins_t p;
    logic [3:0] lanes;
    logic wide;
    logic blk;
    logic active;
    p = smcm_pkg::PINS_IDLE;
    lanes = laneMask(st.cur.mode.busWidthSel) & st.cur.byteEn;
    wide = isWide(st.cur.mode.busWidthSel);
    blk = floatBlocks(st.floatCnt, st.floatCs, st.cur);
    active = (st.phase == smcm_pkg::PH_PULSE) ||
             (st.phase == smcm_pkg::PH_HOLD) ||
             ((st.phase == smcm_pkg::PH_SETUP) && !(blk && !st.floatOpt));
    if (active) begin
      p.chipSelN[st.cur.chipSel] = 1'b0;
      // Write data waits until the float period and turnaround are over.
      p.dataOe = st.cur.write && !blk; // RL6
      p.dataOut = st.cur.wdata;
      if (wide && !st.cur.mode.byteAccessType) begin
        p.byteSelectN = ~lanes; // RL3
      end
      if (st.phase == smcm_pkg::PH_PULSE) begin
        if (!st.cur.write) begin
          p.readStrobeN = 1'b0; // RL2
        end else if (wide && st.cur.mode.byteAccessType) begin
          p.byteWriteStrobeN = ~lanes; // RL2
        end else begin
          p.writeStrobeN = 1'b0; // RL1
        end
      end
    end
    return p;
  endfunction : pinsFor

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic blk;
    logic pageHit;
    logic [6:0] pulseLen;
    blk = 1'b0;
    pageHit = 1'b0;
    pulseLen = 7'h00;
    s_d = s_q;
    s_d.rdValid = 1'b0;
    s_d.dinMeta = dataIn;
    s_d.dinSync = s_q.dinMeta;
    // Float period runs down one cycle at a time.
    if (s_q.floatCnt != 5'h00) begin
      s_d.floatCnt = 5'(s_q.floatCnt - 5'h01); // RL7
    end
    blk = floatBlocks(s_q.floatCnt, s_q.floatCs, s_q.cur);
    pageHit = s_q.pageOpen && s_q.cur.mode.pageReadEn &&
              (s_q.pageCs == s_q.cur.chipSel) &&
              (pageBase(s_q.cur.addr, s_q.cur.mode.pageSizeSel) ==
               pageBase(s_q.pageAddr, s_q.cur.mode.pageSizeSel));
    if (s_q.cur.write) begin
      pulseLen = s_q.cur.writePulseLen;
    end else if (pageHit) begin
      pulseLen = s_q.cur.readStrobePulseLen; // RL13
    end else begin
      pulseLen = s_q.cur.csReadPulseLen; // RL13
    end
    case (s_q.phase)
      smcm_pkg::PH_IDLE: begin
        if (reqValid && s_q.reqReady) begin
          s_d.cur = req;
          s_d.reqReady = 1'b0;
          s_d.cnt = {2'h0, req.setupLen};
          s_d.phase = smcm_pkg::PH_SETUP;
        end
      end
      smcm_pkg::PH_SETUP: begin
        if (blk && !s_q.floatOpt) begin
          s_d.cnt = s_q.cnt; // RL9
        end else if (s_q.cnt != 8'h00) begin
          s_d.cnt = 8'(s_q.cnt - 8'h01); // RL8
        end else if (!blk) begin
          s_d.phase = smcm_pkg::PH_PULSE;
          s_d.cnt = (pulseLen == 7'h00) ? 8'h00 : 8'(pulseLen - 7'h01);
        end
      end
      smcm_pkg::PH_PULSE: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = 8'(s_q.cnt - 8'h01);
        end else begin
          if (!s_q.cur.write) begin
            s_d.rdValid = 1'b1;
            // The pin synchroniser delays data by two cycles, so a read
            // pulse shorter than three cycles returns what the bus showed
            // before the strobe fell.
            s_d.rdData = s_q.dinSync;
            // Read strobe rises here: it starts the float when it controls.
            if (s_q.cur.mode.readModeStrobe) begin
              s_d.floatCnt = 5'({1'b0, s_q.cur.mode.floatCycleCount} +
                                smcm_pkg::TURNAROUND_CYCLES); // RL12
              s_d.floatCs = s_q.cur.chipSel;
              s_d.floatOpt = s_q.cur.mode.floatOptimizeEn;
            end
          end
          s_d.phase = smcm_pkg::PH_HOLD;
          s_d.cnt = {2'h0, s_q.cur.holdLen};
        end
      end
      smcm_pkg::PH_HOLD: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = 8'(s_q.cnt - 8'h01);
        end else begin
          // Chip select rises here: it starts the float when it controls.
          if (!s_q.cur.write && !s_q.cur.mode.readModeStrobe) begin
            s_d.floatCnt = 5'({1'b0, s_q.cur.mode.floatCycleCount} +
                              smcm_pkg::TURNAROUND_CYCLES); // RL5
            s_d.floatCs = s_q.cur.chipSel;
            s_d.floatOpt = s_q.cur.mode.floatOptimizeEn;
          end
          // A page stays open only after a page-mode read.
          s_d.pageOpen = !s_q.cur.write && s_q.cur.mode.pageReadEn; // RL10
          s_d.pageCs = s_q.cur.chipSel;
          s_d.pageAddr = s_q.cur.addr;
          s_d.phase = smcm_pkg::PH_IDLE;
          s_d.reqReady = 1'b1;
        end
      end
      default: begin
        s_d.phase = smcm_pkg::PH_IDLE;
      end
    endcase
    // Busy flag is registered so that the output comes from a flip-flop.
    s_d.busy = (s_d.floatCnt != 5'h00); // RL7
    s_d.pins = pinsFor(s_d);
  end

  //////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
      s_q.phase <= smcm_pkg::PH_IDLE;
      s_q.pins <= smcm_pkg::PINS_IDLE;
      s_q.reqReady <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from the state register.

  assign reqReady = s_q.reqReady;
  assign rdValid = s_q.rdValid;
  assign rdData = s_q.rdData;
  assign busBusy = s_q.busy;
  assign pins = s_q.pins;

endmodule : smcm_static_mem_ctrl
`default_nettype wire
